// ---- ldc_pkg.sv ----
// constants and carrier types shared by the led driver control register bank
package ldc_pkg;
  localparam int CH_N = 10;
  localparam int FAULT_N = 12;
  // register addresses
  localparam logic [7:0] ADDR_EN_HI = 8'h00;
  localparam logic [7:0] ADDR_EN_LO = 8'h01;
  localparam logic [7:0] ADDR_PER_HI = 8'h02;
  localparam logic [7:0] ADDR_PER_LO = 8'h03;
  localparam logic [7:0] ADDR_OVP = 8'h04;
  localparam logic [7:0] ADDR_DITHER = 8'h05;
  localparam logic [7:0] ADDR_FMODE_HI = 8'h06;
  localparam logic [7:0] ADDR_FMODE_LO = 8'h07;
  localparam logic [7:0] ADDR_GROUP_HI = 8'h08;
  localparam logic [7:0] ADDR_GROUP_LO = 8'h09;
  localparam logic [7:0] ADDR_SDT_FIRST = 8'h0a;
  localparam logic [7:0] ADDR_SDT_LAST = 8'h0e;
  localparam logic [7:0] ADDR_AUX = 8'h0f;
  localparam logic [7:0] ADDR_TON_FIRST = 8'h10;
  localparam logic [7:0] ADDR_TON_LAST = 8'h23;
  localparam logic [7:0] ADDR_LOAD = 8'h24;
  localparam logic [7:0] ADDR_REGHYS = 8'h25;
  localparam logic [7:0] ADDR_CUR_FIRST = 8'h26;
  localparam logic [7:0] ADDR_CUR_LAST = 8'h2f;
  localparam logic [7:0] ADDR_FSTAT = 8'h30;
  localparam logic [7:0] ADDR_REGSTAT = 8'h32;
  localparam logic [7:0] ADDR_GSTAT = 8'h34;
  localparam logic [7:0] ADDR_SSTAT = 8'h36;
  localparam logic [7:0] ADDR_LAT_FAULT = 8'h38;
  localparam logic [7:0] ADDR_LAT_REG = 8'h3a;
  localparam logic [7:0] ADDR_LAT_GND = 8'h3c;
  localparam logic [7:0] ADDR_LAT_STR = 8'h3e;
  // field positions
  localparam int DERATE_BIT = 2;
  localparam int BLEED_BIT = 7;
  localparam int HEADROOM_BIT = 3;
  localparam int BAND_BIT = 1;
  localparam int SLOPE_BIT = 0;
  localparam int SDT_HI_LSB = 4;
  localparam int AUX1_LSB = 3;
  localparam int FAULT_REG_IDX = 7;
  localparam int FAULT_GND_IDX = 9;
  localparam int FAULT_STR_IDX = 11;
  // reset values
  localparam logic [9:0] EN_RST = 10'h000;
  localparam logic [12:0] PER_RST = 13'h0fff;
  localparam logic [4:0] OVP_RST = 5'h1c;
  localparam logic [11:0] FMODE_RST = 12'h000;
  localparam logic [11:0] FMODE_WR_MASK = 12'h6ff;
  localparam logic [15:0] TON_RST = 16'h0000;
  localparam logic [15:0] TON_FULL = 16'hffff;
  localparam logic [5:0] CUR_RST = 6'h1f;
  // scaling
  localparam logic [15:0] OVP_BASE_MV = 16'h1f40;
  localparam logic [15:0] OVP_STEP_MV = 16'h03e8;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int TON_STEP_NS = 150;
  localparam int PER_STEP_NS = 1500;
  localparam int TON_STEP_CYC = TON_STEP_NS * (CLK_HZ / 1000000) / 1000;
  localparam int PER_PER_TON = PER_STEP_NS / TON_STEP_NS;

  typedef struct packed {
    logic [4:0] ovp_code;
    logic [1:0] spread;
    logic derate;
    logic [11:0] fault_mode;
    logic bleed;
    logic headroom;
    logic band;
    logic slope;
    logic [1:0] aux_one;
    logic [1:0] aux_two;
  } ldc_cfg_t;

  typedef struct packed {
    logic [11:0] fault;
    logic [9:0] regul;
    logic [9:0] gnd;
    logic [9:0] str;
    logic ext_sync;
    logic startup_done;
  } ldc_stat_t;
endpackage

// ---- ldc_sync3.sv ----
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ldc_sync3 #(
  parameter int W = 8
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;

  // stage one feeds stage two only
  assign out_d = (s2_q & s3_q) | (sync_out & (s2_q | s3_q));

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_out <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= out_d;
    end
  end
endmodule // ldc_sync3

// ---- ldc_pwm_slot.sv ----
// one dimming channel: phase-shifted on-time compare against the shared period counter
`timescale 1ns/1ps
module ldc_pwm_slot
  import ldc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [16:0] count_in,
  input wire logic [16:0] period_in,
  input wire logic [16:0] start_in,
  input wire logic [15:0] ontime_in,
  input wire logic enable_in,
  output logic on_out
);
  logic [16:0] phase;
  logic full;
  logic on_d;

  assign phase = (count_in >= start_in) ? 17'(count_in - start_in)
                                        : 17'(count_in + period_in - start_in);
  assign full = (ontime_in == TON_FULL) || ({1'b0, ontime_in} > period_in);
  assign on_d = enable_in && (ontime_in != TON_RST)
                && (full || (phase < {1'b0, ontime_in}));

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      on_out <= 1'b0;
    end else begin
      on_out <= on_d;
    end
  end
endmodule // ldc_pwm_slot

// ---- ldc_regbank.sv ----
// register bank, dimming timebase and fault reporting of the ten-channel led driver
`timescale 1ns/1ps
// Notes on behaviour
// - trip level is 8 V plus 1 V per step of the 5-bit code
// - trip code resets to 28, a 36 V trip level
// - bit 2 of the dither register enables thermal derating
// - 2-bit spread code, 5 percent per step, suppressed under external sync
// - 12-bit fault handling field; fixed bits keep default and ignore writes
// - ungrouped channel dims in its own slot with its own on-time
// - grouped channels follow slot and on-time of lowest chain member
// - grouping bit k joins channel k+2 to channel k+1
// - 3-bit short threshold per channel, two per register, five registers
// - on-time is 16 bits in 150 ns steps against the shared period
// - all-ones on-time or on-time beyond the period keeps channel on
// - on-times reset to zero and zero keeps the channel dark
// - on-times buffered until any write to the load strobe applies all
// - bleed load enabled by bit 7 applies during startup only
// - 6-bit current code, 1 mA steps over 1 mA base, reset 0x1f
// - twelve fault status bits; active-low fault pin low while any fault
// - fault bit clears when resolved, latched copy stays set
// - per-channel out-of-regulation bits, tied to fault 8
// - per-channel ground-short bits, tied to fault 10, halt initialisation
// - per-channel string-short bits, tied to fault 12
// - dimming period is code plus one times 1.5 us
// - per-channel enable bit switches each string
module ldc_regbank
  import ldc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [11:0] fault_in,
  input wire logic [9:0] regulation_in,
  input wire logic [9:0] gnd_short_in,
  input wire logic [9:0] str_short_in,
  input wire logic ext_sync_in,
  input wire logic startup_done_in,
  output logic [9:0] led_on_out,
  output logic fault_flag_pin_n_out,
  output logic init_halt_out,
  output logic bleed_load_out,
  output logic [15:0] ovp_trip_mv_out,
  output ldc_cfg_t cfg_out,
  output logic [29:0] short_threshold_out,
  output logic [59:0] sink_current_out
);
  // picks the byte of a 16-bit pair; even address holds the high byte
  function automatic logic [7:0] pair_byte(input logic [15:0] w, input logic lo);
    pair_byte = lo ? w[7:0] : w[15:8];
  endfunction

  logic [9:0] en_q;
  logic [12:0] per_q;
  logic [4:0] ovp_q;
  logic [2:0] dith_q;
  logic [11:0] fmode_q;
  logic [8:0] group_q;
  logic [2:0] sdt_q [CH_N];
  logic [4:0] aux_q;
  logic [7:0] ton_hi_q;
  logic [15:0] ton_buf_q [CH_N];
  logic [15:0] ton_act_q [CH_N];
  logic [3:0] reghys_q;
  logic [5:0] cur_q [CH_N];
  logic [11:0] lat_fault_q;
  logic [9:0] lat_reg_q;
  logic [9:0] lat_gnd_q;
  logic [9:0] lat_str_q;
  logic [1:0] pre_q;
  logic [16:0] cnt_q;
  ldc_stat_t st;

  ldc_sync3 #(.W($bits(ldc_stat_t))) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in({fault_in, regulation_in, gnd_short_in, str_short_in, ext_sync_in,
               startup_done_in}),
    .sync_out(st)
  );

  // address decode
  logic [7:0] a;
  logic wr_en_hi, wr_en_lo, wr_per_hi, wr_per_lo, wr_ovp, wr_dith;
  logic wr_fm_hi, wr_fm_lo, wr_gr_hi, wr_gr_lo, wr_sdt, wr_aux;
  logic wr_ton, wr_ton_hi, wr_ton_lo, wr_load, wr_reghys, wr_cur;
  logic [7:0] sdt_off, ton_off, cur_off;
  logic [3:0] sdt_idx, ton_idx, cur_idx;
  assign a = reg_addr_in;
  assign wr_en_hi = reg_wr_in && (a == ADDR_EN_HI);
  assign wr_en_lo = reg_wr_in && (a == ADDR_EN_LO);
  assign wr_per_hi = reg_wr_in && (a == ADDR_PER_HI);
  assign wr_per_lo = reg_wr_in && (a == ADDR_PER_LO);
  assign wr_ovp = reg_wr_in && (a == ADDR_OVP);
  assign wr_dith = reg_wr_in && (a == ADDR_DITHER);
  assign wr_fm_hi = reg_wr_in && (a == ADDR_FMODE_HI);
  assign wr_fm_lo = reg_wr_in && (a == ADDR_FMODE_LO);
  assign wr_gr_hi = reg_wr_in && (a == ADDR_GROUP_HI);
  assign wr_gr_lo = reg_wr_in && (a == ADDR_GROUP_LO);
  assign wr_sdt = reg_wr_in && (a >= ADDR_SDT_FIRST) && (a <= ADDR_SDT_LAST);
  assign wr_aux = reg_wr_in && (a == ADDR_AUX);
  assign wr_ton = reg_wr_in && (a >= ADDR_TON_FIRST) && (a <= ADDR_TON_LAST);
  assign wr_ton_hi = wr_ton && !a[0];
  assign wr_ton_lo = wr_ton && a[0];
  assign wr_load = reg_wr_in && (a == ADDR_LOAD);
  assign wr_reghys = reg_wr_in && (a == ADDR_REGHYS);
  assign wr_cur = reg_wr_in && (a >= ADDR_CUR_FIRST) && (a <= ADDR_CUR_LAST);
  assign sdt_off = 8'(a - ADDR_SDT_FIRST);
  assign ton_off = 8'(a - ADDR_TON_FIRST);
  assign cur_off = 8'(a - ADDR_CUR_FIRST);
  assign sdt_idx = {sdt_off[2:0], 1'b0};
  assign ton_idx = ton_off[4:1];
  assign cur_idx = cur_off[3:0];

  // configuration registers
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      en_q <= EN_RST;
      per_q <= PER_RST;
      ovp_q <= OVP_RST;
      dith_q <= '0;
      fmode_q <= FMODE_RST;
      group_q <= '0;
      aux_q <= '0;
      reghys_q <= '0;
      ton_hi_q <= '0;
    end else begin
      if (wr_en_hi) en_q[9:8] <= reg_wdata_in[1:0];
      if (wr_en_lo) en_q[7:0] <= reg_wdata_in;
      if (wr_per_hi) per_q[12:8] <= reg_wdata_in[4:0];
      if (wr_per_lo) per_q[7:0] <= reg_wdata_in;
      if (wr_ovp) ovp_q <= reg_wdata_in[4:0];
      if (wr_dith) dith_q <= reg_wdata_in[2:0];
      // protected fault-mode bits keep their default
      if (wr_fm_hi) begin
        fmode_q[11:8] <= (reg_wdata_in[3:0] & FMODE_WR_MASK[11:8])
                         | (FMODE_RST[11:8] & ~FMODE_WR_MASK[11:8]);
      end
      if (wr_fm_lo) begin
        fmode_q[7:0] <= (reg_wdata_in & FMODE_WR_MASK[7:0])
                        | (FMODE_RST[7:0] & ~FMODE_WR_MASK[7:0]);
      end
      if (wr_gr_hi) group_q[8] <= reg_wdata_in[0];
      if (wr_gr_lo) group_q[7:0] <= reg_wdata_in;
      if (wr_aux) aux_q <= reg_wdata_in[4:0];
      if (wr_reghys) begin
        reghys_q <= {reg_wdata_in[BLEED_BIT], reg_wdata_in[HEADROOM_BIT],
                     reg_wdata_in[BAND_BIT], reg_wdata_in[SLOPE_BIT]};
      end
      if (wr_ton_hi) ton_hi_q <= reg_wdata_in;
    end
  end

  // per-channel arrays; buffered on-times reach the active set only on the strobe
  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          sdt_q[gi] <= '0;
          cur_q[gi] <= CUR_RST;
          ton_buf_q[gi] <= TON_RST;
          ton_act_q[gi] <= TON_RST;
        end else begin
          if (wr_sdt && (sdt_idx == 4'(gi))) sdt_q[gi] <= reg_wdata_in[6:4];
          if (wr_sdt && (sdt_idx + 4'h1 == 4'(gi))) sdt_q[gi] <= reg_wdata_in[2:0];
          if (wr_cur && (cur_idx == 4'(gi))) cur_q[gi] <= reg_wdata_in[5:0];
          // low byte completes the pair; only then does the buffer change
          if (wr_ton_lo && (ton_idx == 4'(gi))) begin
            ton_buf_q[gi] <= {ton_hi_q, reg_wdata_in};
          end
          if (wr_load) ton_act_q[gi] <= ton_buf_q[gi];
        end
      end
      assign short_threshold_out[gi*3 +: 3] = sdt_q[gi];
      assign sink_current_out[gi*6 +: 6] = cur_q[gi];
    end
  endgenerate

  // dimming timebase: 150 ns tick, period in ticks is ten per 1.5 us step
  logic tick;
  logic [16:0] per_ticks;
  logic [16:0] slot_w;
  assign tick = (pre_q == 2'(TON_STEP_CYC - 1));
  assign slot_w = {4'h0, per_q} + 17'h00001;
  assign per_ticks = 17'(slot_w * 17'(PER_PER_TON));

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else begin
      pre_q <= tick ? 2'h0 : 2'(pre_q + 2'h1);
      if (tick) cnt_q <= (cnt_q >= per_ticks - 17'h00001) ? 17'h0 : 17'(cnt_q + 17'h1);
    end
  end

  // group leader: channel i follows channel i-1 when grouping bit i-1 is set
  logic [3:0] lead [CH_N];
  assign lead[0] = 4'h0;
  generate
    for (gi = 1; gi < CH_N; gi++) begin : g_lead
      assign lead[gi] = group_q[gi-1] ? lead[gi-1] : 4'(gi);
    end
    for (gi = 0; gi < CH_N; gi++) begin : g_pwm
      logic [16:0] start;
      assign start = 17'(slot_w * {13'h0, lead[gi]});
      ldc_pwm_slot u_slot (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .count_in(cnt_q),
        .period_in(per_ticks),
        .start_in(start),
        .ontime_in(ton_act_q[lead[gi]]),
        .enable_in(en_q[gi]),
        .on_out(led_on_out[gi])
      );
    end
  endgenerate

  // status: per-channel bits fold into their general fault numbers
  logic [11:0] fault_now;
  always_comb begin
    fault_now = st.fault;
    fault_now[FAULT_REG_IDX] = st.fault[FAULT_REG_IDX] | (|st.regul);
    fault_now[FAULT_GND_IDX] = st.fault[FAULT_GND_IDX] | (|st.gnd);
    fault_now[FAULT_STR_IDX] = st.fault[FAULT_STR_IDX] | (|st.str);
  end

  // latched history cleared by reading; a new event in the same cycle wins
  logic rd_lf_hi, rd_lf_lo, rd_lr_hi, rd_lr_lo, rd_lg_hi, rd_lg_lo, rd_ls_hi, rd_ls_lo;
  logic [11:0] clr_lf;
  logic [9:0] clr_lr, clr_lg, clr_ls;
  assign rd_lf_hi = reg_rd_in && (a == ADDR_LAT_FAULT);
  assign rd_lf_lo = reg_rd_in && (a == ADDR_LAT_FAULT + 8'h01);
  assign rd_lr_hi = reg_rd_in && (a == ADDR_LAT_REG);
  assign rd_lr_lo = reg_rd_in && (a == ADDR_LAT_REG + 8'h01);
  assign rd_lg_hi = reg_rd_in && (a == ADDR_LAT_GND);
  assign rd_lg_lo = reg_rd_in && (a == ADDR_LAT_GND + 8'h01);
  assign rd_ls_hi = reg_rd_in && (a == ADDR_LAT_STR);
  assign rd_ls_lo = reg_rd_in && (a == ADDR_LAT_STR + 8'h01);
  assign clr_lf = {{4{rd_lf_hi}}, {8{rd_lf_lo}}};
  assign clr_lr = {{2{rd_lr_hi}}, {8{rd_lr_lo}}};
  assign clr_lg = {{2{rd_lg_hi}}, {8{rd_lg_lo}}};
  assign clr_ls = {{2{rd_ls_hi}}, {8{rd_ls_lo}}};

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      lat_fault_q <= '0;
      lat_reg_q <= '0;
      lat_gnd_q <= '0;
      lat_str_q <= '0;
    end else begin
      lat_fault_q <= (lat_fault_q & ~clr_lf) | fault_now;
      lat_reg_q <= (lat_reg_q & ~clr_lr) | st.regul;
      lat_gnd_q <= (lat_gnd_q & ~clr_lg) | st.gnd;
      lat_str_q <= (lat_str_q & ~clr_ls) | st.str;
    end
  end

  // read data; the load strobe and unmapped addresses read zero
  logic [7:0] rd_d;
  logic lo;
  assign lo = a[0];
  always_comb begin
    rd_d = 8'h00;
    if (a == ADDR_EN_HI || a == ADDR_EN_LO) begin
      rd_d = pair_byte({6'h0, en_q}, lo);
    end else if (a == ADDR_PER_HI || a == ADDR_PER_LO) begin
      rd_d = pair_byte({3'h0, per_q}, lo);
    end else if (a == ADDR_OVP) begin
      rd_d = {3'h0, ovp_q};
    end else if (a == ADDR_DITHER) begin
      rd_d = {5'h0, dith_q};
    end else if (a == ADDR_FMODE_HI || a == ADDR_FMODE_LO) begin
      rd_d = pair_byte({4'h0, fmode_q}, lo);
    end else if (a == ADDR_GROUP_HI || a == ADDR_GROUP_LO) begin
      rd_d = pair_byte({7'h0, group_q}, lo);
    end else if (a >= ADDR_SDT_FIRST && a <= ADDR_SDT_LAST) begin
      rd_d = {1'b0, sdt_q[sdt_idx], 1'b0, sdt_q[sdt_idx + 4'h1]};
    end else if (a == ADDR_AUX) begin
      rd_d = {3'h0, aux_q};
    end else if (a >= ADDR_TON_FIRST && a <= ADDR_TON_LAST) begin
      rd_d = pair_byte(ton_buf_q[ton_idx], lo);
    end else if (a == ADDR_REGHYS) begin
      rd_d = {reghys_q[3], 3'h0, reghys_q[2], 1'b0, reghys_q[1], reghys_q[0]};
    end else if (a >= ADDR_CUR_FIRST && a <= ADDR_CUR_LAST) begin
      rd_d = {2'h0, cur_q[cur_idx]};
    end else if (a == ADDR_FSTAT || a == ADDR_FSTAT + 8'h01) begin
      rd_d = pair_byte({4'h0, fault_now}, lo);
    end else if (a == ADDR_REGSTAT || a == ADDR_REGSTAT + 8'h01) begin
      rd_d = pair_byte({6'h0, st.regul}, lo);
    end else if (a == ADDR_GSTAT || a == ADDR_GSTAT + 8'h01) begin
      rd_d = pair_byte({6'h0, st.gnd}, lo);
    end else if (a == ADDR_SSTAT || a == ADDR_SSTAT + 8'h01) begin
      rd_d = pair_byte({6'h0, st.str}, lo);
    end else if (a == ADDR_LAT_FAULT || a == ADDR_LAT_FAULT + 8'h01) begin
      rd_d = pair_byte({4'h0, lat_fault_q}, lo);
    end else if (a == ADDR_LAT_REG || a == ADDR_LAT_REG + 8'h01) begin
      rd_d = pair_byte({6'h0, lat_reg_q}, lo);
    end else if (a == ADDR_LAT_GND || a == ADDR_LAT_GND + 8'h01) begin
      rd_d = pair_byte({6'h0, lat_gnd_q}, lo);
    end else if (a == ADDR_LAT_STR || a == ADDR_LAT_STR + 8'h01) begin
      rd_d = pair_byte({6'h0, lat_str_q}, lo);
    end
  end

  // derived outputs, all registered
  ldc_cfg_t cfg_d;
  logic [15:0] ovp_mv_d;
  always_comb begin
    cfg_d.ovp_code = ovp_q;
    cfg_d.spread = st.ext_sync ? 2'h0 : dith_q[1:0];
    cfg_d.derate = dith_q[DERATE_BIT];
    cfg_d.fault_mode = fmode_q;
    cfg_d.bleed = reghys_q[3];
    cfg_d.headroom = reghys_q[2];
    cfg_d.band = reghys_q[1];
    cfg_d.slope = reghys_q[0];
    cfg_d.aux_one = aux_q[AUX1_LSB +: 2];
    cfg_d.aux_two = aux_q[1:0];
  end
  assign ovp_mv_d = 16'(OVP_BASE_MV + OVP_STEP_MV * {11'h0, ovp_q});

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
      fault_flag_pin_n_out <= 1'b1;
      init_halt_out <= 1'b0;
      bleed_load_out <= 1'b0;
      ovp_trip_mv_out <= 16'(OVP_BASE_MV + OVP_STEP_MV * {11'h0, OVP_RST});
      cfg_out <= '0;
    end else begin
      if (reg_rd_in) reg_rdata_out <= rd_d;
      fault_flag_pin_n_out <= ~(|fault_now);
      init_halt_out <= (|st.gnd) && !st.startup_done;
      bleed_load_out <= reghys_q[3] && !st.startup_done;
      ovp_trip_mv_out <= ovp_mv_d;
      cfg_out <= cfg_d;
    end
  end
endmodule // ldc_regbank

// ---- ldc_ctl_model.sv ----
// controller model driving the register strobe port
`timescale 1ns/1ps
module ldc_ctl_model
  import ldc_pkg::*;
(
  input wire logic mclk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  initial {wr_out, rd_out, addr_out, wdata_out} = 18'h0;
  // released lines show the inverse so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    {wr_out, addr_out, wdata_out} <= {1'b1, a, d};
    @(posedge mclk_in);
    {wr_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    {rd_out, addr_out} <= {1'b1, a};
    @(posedge mclk_in);
    {rd_out, addr_out} <= {1'b0, ~a};
    @(posedge mclk_in);
    #1 d = rdata_in;
  endtask
  // callers keep on-times at 7 or more
  task automatic ton(input int ch, input logic [15:0] v);
    wr(ADDR_TON_FIRST + 8'(2 * ch), v[15:8]);
    wr(ADDR_TON_FIRST + 8'(2 * ch + 1), v[7:0]);
  endtask
endmodule // ldc_ctl_model

// ---- ldc_regbank_chk.sv ----
// port assertions for the led driver register bank
`timescale 1ns/1ps
module ldc_regbank_chk
  import ldc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [11:0] fault_in,
  input wire logic [9:0] regulation_in,
  input wire logic [9:0] gnd_short_in,
  input wire logic [9:0] str_short_in,
  input wire logic ext_sync_in,
  input wire logic startup_done_in,
  input wire logic fault_flag_pin_n_out,
  input wire logic init_halt_out,
  input wire logic bleed_load_out,
  input wire logic [15:0] ovp_trip_mv_out,
  input wire ldc_cfg_t cfg_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // async inputs take several edges, hence the held antecedents
  wire quiet = ({fault_in, regulation_in, gnd_short_in, str_short_in} == 42'h0);
  wire lat_rd = reg_rd_in && (reg_addr_in == ADDR_LAT_FAULT + 8'h01);
  a_trip_follows_code: assert property (reg_wr_in && reg_addr_in == ADDR_OVP |->
    ##2 ovp_trip_mv_out == OVP_BASE_MV + OVP_STEP_MV * $past(reg_wdata_in[4:0], 2))
    else $error("trip level wrong");
  a_spread_sync_off: assert property (ext_sync_in [*6] |-> cfg_out.spread == 2'h0)
    else $error("spread under sync");
  a_mode_fixed_bits: assert property (!cfg_out.fault_mode[8] && !cfg_out.fault_mode[11])
    else $error("fixed mode bit moved");
  a_pin_on_fault: assert property (!quiet [*7] |-> !fault_flag_pin_n_out)
    else $error("fault pin not low");
  a_pin_idle_high: assert property (quiet [*7] |-> fault_flag_pin_n_out)
    else $error("fault pin low idle");
  a_latch_read_clear: assert property (quiet [*8] ##0 lat_rd ##1
    (quiet && !reg_rd_in) [*2] ##1 (quiet && lat_rd) |=> reg_rdata_out == 8'h00)
    else $error("latched not cleared");
  a_halt_after_start: assert property (startup_done_in [*6] |-> !init_halt_out)
    else $error("halt after startup");
  a_bleed_in_start: assert property ((!startup_done_in && cfg_out.bleed) [*6]
    |-> bleed_load_out) else $error("bleed load missing");
  a_bleed_released: assert property (startup_done_in [*6] |-> !bleed_load_out)
    else $error("bleed load stuck");
endmodule // ldc_regbank_chk

bind ldc_regbank ldc_regbank_chk ldc_regbank_chk_i (.mclk_in, .reset_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .fault_in, .regulation_in,
  .gnd_short_in, .str_short_in, .ext_sync_in, .startup_done_in, .fault_flag_pin_n_out,
  .init_halt_out, .bleed_load_out, .ovp_trip_mv_out, .cfg_out);

// ---- ldc_regbank_test.sv ----
// self-checking bench for the led driver register bank
`timescale 1ns/1ps
module ldc_regbank_test;
  import ldc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ldc_row_t;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic reg_wr_in, reg_rd_in, fault_flag_pin_n_out, init_halt_out, bleed_load_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd;
  logic [11:0] fault_in = 12'h000;
  logic [9:0] regulation_in = 10'h000, gnd_short_in = 10'h000, str_short_in = 10'h000;
  logic ext_sync_in = 1'b0, startup_done_in = 1'b0;
  logic [9:0] led_on_out;
  logic [15:0] ovp_trip_mv_out;
  ldc_cfg_t cfg_out;
  logic [29:0] short_threshold_out;
  logic [59:0] sink_current_out;
  int fail_count = 0, tests_run = 0, cycles = 0, h0, h2, hd;
  // address, data written, value read back
  ldc_row_t rows [11] = '{'{8'h04, 8'h0a, 8'h0a}, '{8'h05, 8'h07, 8'h07},
    '{8'h06, 8'h0f, 8'h06}, '{8'h07, 8'hff, 8'hff}, '{8'h08, 8'h01, 8'h01},
    '{8'h09, 8'h41, 8'h41}, '{8'h0a, 8'h53, 8'h53}, '{8'h0f, 8'h1b, 8'h1b},
    '{8'h25, 8'h8b, 8'h8b}, '{8'h26, 8'h3f, 8'h3f}, '{8'h50, 8'hff, 8'h00}};
  ldc_regbank ldc_regbank_i (.mclk_in, .reset_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .fault_in, .regulation_in, .gnd_short_in, .str_short_in,
    .ext_sync_in, .startup_done_in, .led_on_out, .fault_flag_pin_n_out, .init_halt_out,
    .bleed_load_out, .ovp_trip_mv_out, .cfg_out, .short_threshold_out, .sink_current_out);
  ldc_ctl_model ldc_ctl_model_i (.mclk_in, .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out));
  always #25 mclk_in = ~mclk_in;
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check_port(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    ldc_ctl_model_i.rd(a, rd);
    tests_run++;
    if (rd !== e) begin
      fail_count++;
      $display("mismatch read %h expected %h seen %h", a, e, rd);
    end
  endtask
  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    check_rd(ADDR_OVP, 8'h1c);
    check_rd(ADDR_CUR_FIRST, 8'h1f);
    check_rd(ADDR_TON_FIRST + 8'h01, 8'h00);
    check_port("trip", 16'h8ca0, ovp_trip_mv_out);
    check_port("leds", 16'h0000, 16'(led_on_out));
  endtask
  // sixty cycles span exactly two of the thirty-cycle periods used here
  task automatic measure;
    h0 = 0;
    h2 = 0;
    hd = 0;
    repeat (60) begin
      @(posedge mclk_in);
      #1;
      if (led_on_out[0] === 1'b1) h0++;
      if (led_on_out[2] === 1'b1) h2++;
      if (led_on_out[1] !== led_on_out[0]) hd++;
    end
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      ldc_ctl_model_i.wr(rows[i].a, rows[i].d);
      check_rd(rows[i].a, rows[i].e);
    end
    check_port("trip", 16'h4650, ovp_trip_mv_out);
    check_port("mode", 16'h06ff, 16'(cfg_out.fault_mode));
    check_port("spread", 16'h0003, 16'(cfg_out.spread));
    check_port("derate", 16'h0001, 16'(cfg_out.derate));
    check_port("thresh", 16'h001d, 16'(short_threshold_out[5:0]));
    check_port("current", 16'h003f, 16'(sink_current_out[5:0]));
    check_port("bleed", 16'h0001, 16'(bleed_load_out));
    check_port("code", 16'h000a, 16'(cfg_out.ovp_code));
    check_port("reghys", 16'h000f,
      16'({cfg_out.bleed, cfg_out.headroom, cfg_out.band, cfg_out.slope}));
    @(posedge mclk_in);
    ext_sync_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    ext_sync_in <= 1'b0;
    #1 check_port("spread", 16'h0000, 16'(cfg_out.spread));
    ldc_ctl_model_i.wr(ADDR_PER_HI, 8'h00);
    ldc_ctl_model_i.wr(ADDR_PER_LO, 8'h00);
    ldc_ctl_model_i.wr(ADDR_EN_LO, 8'h07);
    ldc_ctl_model_i.ton(0, 16'h0007);
    ldc_ctl_model_i.ton(1, 16'h0009);
    ldc_ctl_model_i.ton(2, 16'hffff);
    ldc_ctl_model_i.wr(ADDR_TON_FIRST + 8'h06, 8'h12);
    check_rd(ADDR_TON_FIRST + 8'h06, 8'h00);
    measure();
    check_port("dark", 16'h0000, 16'(h0 + h2));
    ldc_ctl_model_i.wr(ADDR_LOAD, 8'h5a);
    measure();
    check_port("duty", 16'h002a, 16'(h0));
    check_port("full", 16'h003c, 16'(h2));
    check_port("group", 16'h0000, 16'(hd));
    ldc_ctl_model_i.ton(0, 16'h000b);
    ldc_ctl_model_i.wr(ADDR_LOAD, 8'h00);
    measure();
    check_port("beyond", 16'h003c, 16'(h0));
    @(posedge mclk_in);
    {fault_in, regulation_in, gnd_short_in, str_short_in} <= {12'h001, 30'h00100804};
    repeat (8) @(posedge mclk_in);
    #1 check_port("pin", 16'h0000, 16'(fault_flag_pin_n_out));
    check_port("halt", 16'h0001, 16'(init_halt_out));
    check_rd(ADDR_FSTAT, 8'h0a);
    check_rd(ADDR_FSTAT + 8'h01, 8'h81);
    check_rd(ADDR_REGSTAT + 8'h01, 8'h01);
    check_rd(ADDR_GSTAT + 8'h01, 8'h02);
    check_rd(ADDR_SSTAT + 8'h01, 8'h04);
    @(posedge mclk_in);
    {fault_in, regulation_in, gnd_short_in, str_short_in, startup_done_in} <= {42'h0, 1'b1};
    repeat (10) @(posedge mclk_in);
    #1 check_port("pin", 16'h0001, 16'(fault_flag_pin_n_out));
    check_port("halt", 16'h0000, 16'(init_halt_out));
    check_port("bleed", 16'h0000, 16'(bleed_load_out));
    check_rd(ADDR_FSTAT + 8'h01, 8'h00);
    check_rd(ADDR_LAT_FAULT + 8'h01, 8'h81);
    check_rd(ADDR_LAT_FAULT + 8'h01, 8'h00);
    @(posedge mclk_in);
    do_reset();
    summarize();
  end
endmodule // ldc_regbank_test
